/* File: shared/rtcsb_consts.svh */
`ifndef RTCSB_CONSTS_SVH
`define RTCSB_CONSTS_SVH

// mode code: bit 3 selects read, bits 2:0 select the bank
`define RTCSB_MODE_READ_BIT 3
`define RTCSB_CODE_BANK1 3'h1
`define RTCSB_CODE_BANK2 3'h2
`define RTCSB_CODE_BANK3 3'h3
`define RTCSB_CODE_BANK5 3'h5
`define RTCSB_CODE_BANK6 3'h6
`define RTCSB_MODE_RD_BANK1 4'h9
`define RTCSB_MODE_RD_BANK2 4'ha
`define RTCSB_MODE_RD_BANK3 4'hb
`define RTCSB_MODE_RD_BANK6 4'he
`define RTCSB_MODE_WR_BANK1 4'h1
`define RTCSB_MODE_WR_BANK2 4'h2
`define RTCSB_MODE_WR_BANK3 4'h3
`define RTCSB_MODE_WR_BANK6 4'h6

// storage banks 1..3 map to indices 0..2, index 3 means no storage
`define RTCSB_NUM_BANKS 3
`define RTCSB_BANK_NONE 2'h3
`define RTCSB_REGS_PER_BANK 16

// bank 1 layout
`define RTCSB_ADDR_SEC 4'h0
`define RTCSB_ADDR_MIN 4'h1
`define RTCSB_ADDR_HOUR 4'h2
`define RTCSB_ADDR_CTRL 4'he
`define RTCSB_CTRL_HALT_BIT 6
`define RTCSB_SEC_LAST 8'h3b
`define RTCSB_MIN_LAST 8'h3b
`define RTCSB_HOUR_LAST 8'h17
`define RTCSB_REG_RESET 8'h00

// timing
`define RTCSB_CLK_NS 20
`define RTCSB_SEC_NS 1000000000
`define RTCSB_SCLK_HALF_NS 80

`endif

/* File: shared/rtcsb_pkg.sv */
package rtcsb_pkg;

    typedef enum logic [2:0] {
        HS_IDLE,
        HS_SETUP,
        HS_LOW,
        HS_HIGH,
        HS_NEXT,
        HS_WBYTE,
        HS_END,
        HS_GAP
    } rtcsb_hstate_t;

endpackage : rtcsb_pkg

/* File: shared/rtcsb_if.sv */
`timescale 1ns/10ps
interface rtcsb_if;
    logic ce;
    logic sclk;
    logic mosi;
    logic miso;

    modport host (output ce, output sclk, output mosi, input miso);
    modport dev (input ce, input sclk, input mosi, output miso);
endinterface : rtcsb_if

/* File: hw/rtcsb_fifo.sv */
`timescale 1ns/10ps
module rtcsb_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign o_in_ready = count != (AW+1)'(DEPTH);
    assign push = i_in_valid && o_in_ready;
    // output stage is a register so the consumer sees flopped data
    assign pop = (count != '0) && (!o_out_valid || i_out_ready);

    always_ff @(posedge i_clk_sys) begin
        if (push) begin
            mem[wptr] <= i_in_data;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            wptr <= '0;
            rptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wptr <= (wptr == AW'(DEPTH - 1)) ? '0 : wptr + 1'b1;
            end
            if (pop) begin
                rptr <= (rptr == AW'(DEPTH - 1)) ? '0 : rptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_out_valid <= 1'b0;
            o_out_data <= '0;
        end else if (pop) begin
            o_out_valid <= 1'b1;
            o_out_data <= mem[rptr];
        end else if (i_out_ready) begin
            o_out_valid <= 1'b0;
        end
    end
endmodule : rtcsb_fifo

/* File: hw/rtcsb_dev.sv */
`timescale 1ns/10ps
`include "rtcsb_consts.svh"
module rtcsb_dev #(
    parameter int TICK_CYCLES = `RTCSB_SEC_NS / `RTCSB_CLK_NS
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    rtcsb_if.dev link,
    output logic o_halted,
    output logic o_vdet_enable,
    output logic o_soft_reset,
    output logic [7:0] o_sec,
    output logic [7:0] o_min,
    output logic [7:0] o_hour
);
    localparam int PW = $clog2(TICK_CYCLES + 1);

    function automatic logic [1:0] bank_of(input logic [3:0] code);
        case (code[2:0])
            `RTCSB_CODE_BANK1: bank_of = 2'h0;
            `RTCSB_CODE_BANK2: bank_of = 2'h1;
            `RTCSB_CODE_BANK3: bank_of = 2'h2;
            default: bank_of = `RTCSB_BANK_NONE;
        endcase
    endfunction : bank_of

    function automatic logic [7:0] wrap_inc(input logic [7:0] v, input logic [7:0] last);
        wrap_inc = (v >= last) ? 8'h00 : v + 8'h01;
    endfunction : wrap_inc

    logic ce_s1;
    logic ce_s2;
    logic ce_d;
    logic sclk_s1;
    logic sclk_s2;
    logic sclk_d;
    logic mosi_s1;
    logic mosi_s2;

    logic rise;
    logic fall;
    logic ce_fall;
    logic byte_end;
    logic [7:0] new_byte;

    logic in_data;
    logic load_pending;
    logic miso;
    logic [2:0] bcnt;
    logic [3:0] mode;
    logic [3:0] addr;
    logic [7:0] rx;
    logic [7:0] tx;
    logic [7:0] rd_byte;

    logic [7:0] mem [`RTCSB_NUM_BANKS][`RTCSB_REGS_PER_BANK];
    logic [PW-1:0] presc;
    logic halt;
    logic tick;
    logic wr_go;
    logic mem_wr;
    logic sec_wr;
    logic srst_go;

    // two flops on every link input; ce and sclk add a third flop, and edges compare it with the second
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            ce_s1 <= 1'b0;
            ce_s2 <= 1'b0;
            ce_d <= 1'b0;
            sclk_s1 <= 1'b0;
            sclk_s2 <= 1'b0;
            sclk_d <= 1'b0;
            mosi_s1 <= 1'b0;
            mosi_s2 <= 1'b0;
        end else begin
            ce_s1 <= link.ce;
            ce_s2 <= ce_s1;
            ce_d <= ce_s2;
            sclk_s1 <= link.sclk;
            sclk_s2 <= sclk_s1;
            sclk_d <= sclk_s2;
            mosi_s1 <= link.mosi;
            mosi_s2 <= mosi_s1;
        end
    end

    // clock edges only count while chip enable is high
    assign rise = ce_s2 && ce_d && sclk_s2 && !sclk_d;
    assign fall = ce_s2 && ce_d && !sclk_s2 && sclk_d;
    assign ce_fall = ce_d && !ce_s2;
    assign new_byte = {rx[6:0], mosi_s2};
    assign byte_end = rise && (bcnt == 3'h7);

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n || ce_fall || !ce_s2) begin
            // a half-shifted byte is simply forgotten here
            bcnt <= 3'h0;
            in_data <= 1'b0;
            load_pending <= 1'b0;
            rx <= 8'h00;
            if (!i_rst_n) begin
                mode <= 4'h0;
                addr <= 4'h0;
            end
        end else if (rise) begin
            rx <= new_byte;
            bcnt <= bcnt + 3'h1;
            if (bcnt == 3'h7) begin
                if (!in_data) begin
                    mode <= new_byte[7:4];
                    addr <= new_byte[3:0];
                    in_data <= 1'b1;
                    load_pending <= new_byte[4 + `RTCSB_MODE_READ_BIT];
                end else begin
                    addr <= addr + 4'h1;
                    load_pending <= mode[`RTCSB_MODE_READ_BIT];
                end
            end
        end else if (fall && load_pending) begin
            load_pending <= 1'b0;
        end
    end

    // reads from bank 6 or an undefined bank return zero
    always_comb begin
        if (bank_of(mode) != `RTCSB_BANK_NONE) begin
            rd_byte = mem[bank_of(mode)][addr];
        end else begin
            rd_byte = 8'h00;
        end
    end

    // read data moves on falling edges so it is stable over the next high phase
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            tx <= 8'h00;
            miso <= 1'b0;
        end else if (fall) begin
            if (load_pending) begin
                tx <= rd_byte;
                miso <= rd_byte[7];
            end else begin
                tx <= {tx[6:0], 1'b0};
                miso <= tx[6];
            end
        end
    end

    assign link.miso = miso;

    assign wr_go = byte_end && in_data && !mode[`RTCSB_MODE_READ_BIT];
    assign mem_wr = wr_go && (bank_of(mode) != `RTCSB_BANK_NONE);
    assign srst_go = wr_go && ((mode[2:0] == `RTCSB_CODE_BANK5) || (mode[2:0] == `RTCSB_CODE_BANK6));
    assign sec_wr = mem_wr && (bank_of(mode) == 2'h0) && (addr == `RTCSB_ADDR_SEC);
    assign halt = mem[0][`RTCSB_ADDR_CTRL][`RTCSB_CTRL_HALT_BIT];
    assign tick = !halt && (presc == PW'(TICK_CYCLES - 1));

    // the seconds byte restarts the second from its completing edge
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n || sec_wr || srst_go) begin
            presc <= '0;
        end else if (tick) begin
            presc <= '0;
        end else if (!halt) begin
            presc <= presc + 1'b1;
        end
    end

    // a host write in the same cycle as a tick overrides the ticked value
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            for (int b = 0; b < `RTCSB_NUM_BANKS; b++) begin
                for (int a = 0; a < `RTCSB_REGS_PER_BANK; a++) begin
                    mem[b][a] <= `RTCSB_REG_RESET;
                end
            end
        end else begin
            if (srst_go) begin
                mem[0][`RTCSB_ADDR_SEC] <= `RTCSB_REG_RESET;
                mem[0][`RTCSB_ADDR_MIN] <= `RTCSB_REG_RESET;
                mem[0][`RTCSB_ADDR_HOUR] <= `RTCSB_REG_RESET;
                mem[0][`RTCSB_ADDR_CTRL] <= `RTCSB_REG_RESET;
            end else if (tick) begin
                mem[0][`RTCSB_ADDR_SEC] <= wrap_inc(mem[0][`RTCSB_ADDR_SEC], `RTCSB_SEC_LAST);
                if (mem[0][`RTCSB_ADDR_SEC] >= `RTCSB_SEC_LAST) begin
                    mem[0][`RTCSB_ADDR_MIN] <= wrap_inc(mem[0][`RTCSB_ADDR_MIN], `RTCSB_MIN_LAST);
                    if (mem[0][`RTCSB_ADDR_MIN] >= `RTCSB_MIN_LAST) begin
                        mem[0][`RTCSB_ADDR_HOUR] <= wrap_inc(mem[0][`RTCSB_ADDR_HOUR], `RTCSB_HOUR_LAST);
                    end
                end
            end
            if (mem_wr) begin
                mem[bank_of(mode)][addr] <= new_byte;
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_halted <= 1'b0;
            o_vdet_enable <= 1'b0;
            o_soft_reset <= 1'b0;
        end else begin
            o_halted <= halt;
            o_vdet_enable <= !halt;
            o_soft_reset <= srst_go;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_sec <= 8'h00;
            o_min <= 8'h00;
            o_hour <= 8'h00;
        end else begin
            o_sec <= mem[0][`RTCSB_ADDR_SEC];
            o_min <= mem[0][`RTCSB_ADDR_MIN];
            o_hour <= mem[0][`RTCSB_ADDR_HOUR];
        end
    end
endmodule : rtcsb_dev

/* File: hw/rtcsb_host.sv */
`timescale 1ns/10ps
`include "rtcsb_consts.svh"
module rtcsb_host #(
    parameter int HALF_CYCLES = `RTCSB_SCLK_HALF_NS / `RTCSB_CLK_NS,
    parameter int FIFO_DEPTH = 32
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    rtcsb_if.host link,
    input wire logic i_cmd_valid,
    output logic o_cmd_ready,
    input wire logic [3:0] i_cmd_mode,
    input wire logic [3:0] i_cmd_addr,
    input wire logic [4:0] i_cmd_len,
    input wire logic i_wr_valid,
    output logic o_wr_ready,
    input wire logic [7:0] i_wr_data,
    output logic o_rd_valid,
    input wire logic i_rd_ready,
    output logic [7:0] o_rd_data
);
    localparam int DW = $clog2(HALF_CYCLES + 1);

    rtcsb_pkg::rtcsb_hstate_t state;
    logic [DW-1:0] div;
    logic div_done;
    logic ce;
    logic sclk;
    logic mosi;
    logic miso_s1;
    logic miso_s2;
    logic hdr;
    logic rd_mode;
    logic [2:0] bitc;
    logic [4:0] len;
    logic [7:0] sh;
    logic [7:0] rxsh;
    logic push;
    logic fifo_ready;

    assign link.ce = ce;
    assign link.sclk = sclk;
    assign link.mosi = mosi;
    assign div_done = div == DW'(HALF_CYCLES - 1);

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            miso_s1 <= 1'b0;
            miso_s2 <= 1'b0;
        end else begin
            miso_s1 <= link.miso;
            miso_s2 <= miso_s1;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n || div_done || state == rtcsb_pkg::HS_IDLE || state == rtcsb_pkg::HS_NEXT
            || state == rtcsb_pkg::HS_WBYTE) begin
            div <= '0;
        end else begin
            div <= div + 1'b1;
        end
    end

    // miso is sampled at the end of the high phase, after the device's falling-edge update
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            state <= rtcsb_pkg::HS_IDLE;
            o_cmd_ready <= 1'b0;
            o_wr_ready <= 1'b0;
            ce <= 1'b0;
            sclk <= 1'b0;
            mosi <= 1'b0;
            hdr <= 1'b0;
            rd_mode <= 1'b0;
            bitc <= 3'h0;
            len <= 5'h00;
            sh <= 8'h00;
            rxsh <= 8'h00;
            push <= 1'b0;
        end else begin
            push <= 1'b0;
            unique case (state)
                rtcsb_pkg::HS_IDLE: begin
                    o_cmd_ready <= 1'b1;
                    if (i_cmd_valid && o_cmd_ready) begin
                        o_cmd_ready <= 1'b0;
                        ce <= 1'b1;
                        sh <= {i_cmd_mode, i_cmd_addr};
                        rd_mode <= i_cmd_mode[`RTCSB_MODE_READ_BIT];
                        len <= i_cmd_len;
                        hdr <= 1'b1;
                        bitc <= 3'h0;
                        state <= rtcsb_pkg::HS_SETUP;
                    end
                end
                rtcsb_pkg::HS_SETUP: begin
                    if (div_done) begin
                        mosi <= sh[7];
                        state <= rtcsb_pkg::HS_LOW;
                    end
                end
                rtcsb_pkg::HS_LOW: begin
                    if (div_done) begin
                        sclk <= 1'b1;
                        state <= rtcsb_pkg::HS_HIGH;
                    end
                end
                rtcsb_pkg::HS_HIGH: begin
                    if (div_done) begin
                        sclk <= 1'b0;
                        rxsh <= {rxsh[6:0], miso_s2};
                        sh <= {sh[6:0], 1'b0};
                        mosi <= sh[6];
                        bitc <= bitc + 3'h1;
                        if (bitc == 3'h7) begin
                            hdr <= 1'b0;
                            push <= !hdr && rd_mode;
                            if (!hdr) begin
                                len <= len - 5'h01;
                            end
                            state <= rtcsb_pkg::HS_NEXT;
                        end else begin
                            state <= rtcsb_pkg::HS_LOW;
                        end
                    end
                end
                rtcsb_pkg::HS_NEXT: begin
                    // a full read fifo holds the clock low until the user drains it
                    if (len == 5'h00) begin
                        state <= rtcsb_pkg::HS_END;
                    end else if (!rd_mode) begin
                        o_wr_ready <= 1'b1;
                        state <= rtcsb_pkg::HS_WBYTE;
                    end else if (fifo_ready && !push) begin
                        mosi <= 1'b0;
                        state <= rtcsb_pkg::HS_LOW;
                    end
                end
                rtcsb_pkg::HS_WBYTE: begin
                    if (i_wr_valid) begin
                        o_wr_ready <= 1'b0;
                        sh <= i_wr_data;
                        mosi <= i_wr_data[7];
                        state <= rtcsb_pkg::HS_LOW;
                    end
                end
                rtcsb_pkg::HS_END: begin
                    if (div_done) begin
                        ce <= 1'b0;
                        state <= rtcsb_pkg::HS_GAP;
                    end
                end
                rtcsb_pkg::HS_GAP: begin
                    if (div_done) begin
                        state <= rtcsb_pkg::HS_IDLE;
                    end
                end
            endcase
        end
    end

    rtcsb_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) u_rd_fifo (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_in_valid(push),
        .o_in_ready(fifo_ready),
        .i_in_data(rxsh),
        .o_out_valid(o_rd_valid),
        .i_out_ready(i_rd_ready),
        .o_out_data(o_rd_data)
    );
endmodule : rtcsb_host

/* File: verif/rtcsb_chk.sv */
`timescale 1ns/10ps
module rtcsb_chk (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic ce,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic miso
);
    logic sclk_q;
    logic [9:0] bit_cnt;
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rst_n);
    always_ff @(posedge i_clk_sys) begin
        sclk_q <= i_rst_n & sclk;
    end
    // rises are counted per frame so a short frame is seen at ce fall
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n || !ce) begin
            bit_cnt <= 10'h000;
        end else if (sclk && !sclk_q) begin
            bit_cnt <= bit_cnt + 10'h001;
        end
    end
    sequence s_low_half;
        !sclk [*4];
    endsequence
    sequence s_high_half;
        sclk [*4];
    endsequence
    chk_idle_clock_low: assert property (!ce |-> !sclk)
        else $error("sclk moved outside a frame");
    chk_frame_open_quiet: assert property ($rose(ce) |-> s_low_half)
        else $error("sclk rose too soon after ce");
    chk_high_phase_len: assert property ($rose(sclk) |-> s_high_half)
        else $error("sclk high phase too short");
    chk_low_phase_len: assert property (ce && $fell(sclk) |-> s_low_half)
        else $error("sclk low phase too short");
    chk_mosi_held_high: assert property (sclk && $past(sclk) |-> $stable(mosi))
        else $error("mosi changed while sclk high");
    chk_miso_held_high: assert property (sclk && $past(sclk) |-> $stable(miso))
        else $error("miso changed while sclk high");
    chk_whole_byte_end: assert property ($fell(ce) |-> bit_cnt[2:0] == 3'h0 && bit_cnt >= 10'h008)
        else $error("frame ended off a byte boundary");
    chk_frame_gap_len: assert property ($fell(ce) |-> !ce [*4])
        else $error("ce gap too short");
endmodule : rtcsb_chk

/* File: verif/rtc_serial_bank_access_tb.sv */
`timescale 1ns/10ps
`include "rtcsb_consts.svh"
module rtc_serial_bank_access_tb;
    localparam int LIM = 3000;
    localparam int TICK = 20;
    localparam int HALF = 4;
    logic clk, rst_n, cv, cr, wv, wr, rv, rr, halted, vdet, sres;
    logic [3:0] cm, ca;
    logic [4:0] cl;
    logic [7:0] wd, rd, sec, min, hour, hdr, r;
    logic [7:0] wbuf [4];
    logic [7:0] rbuf [4];
    int err_total, check_count, nbits, n, k;
    rtcsb_if u_rtcsb_if ();
    rtcsb_if u_rtcsb_if_2 ();
    rtcsb_host u_rtcsb_host (.i_clk_sys(clk), .i_rst_n(rst_n), .link(u_rtcsb_if.host),
        .i_cmd_valid(cv), .o_cmd_ready(cr), .i_cmd_mode(cm), .i_cmd_addr(ca), .i_cmd_len(cl),
        .i_wr_valid(wv), .o_wr_ready(wr), .i_wr_data(wd), .o_rd_valid(rv), .i_rd_ready(rr), .o_rd_data(rd));
    rtcsb_dev #(.TICK_CYCLES(TICK)) u_rtcsb_dev (.i_clk_sys(clk), .i_rst_n(rst_n), .link(u_rtcsb_if.dev),
        .o_halted(halted), .o_vdet_enable(vdet), .o_soft_reset(sres), .o_sec(sec), .o_min(min), .o_hour(hour));
    rtcsb_dev #(.TICK_CYCLES(TICK)) u_rtcsb_dev_2 (.i_clk_sys(clk), .i_rst_n(rst_n), .link(u_rtcsb_if_2.dev),
        .o_halted(), .o_vdet_enable(), .o_soft_reset(), .o_sec(), .o_min(), .o_hour());
    rtcsb_chk u_rtcsb_chk (.i_clk_sys(clk), .i_rst_n(rst_n), .ce(u_rtcsb_if.ce), .sclk(u_rtcsb_if.sclk),
        .mosi(u_rtcsb_if.mosi), .miso(u_rtcsb_if.miso));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // wire monitor: first eight bits of each frame and the total bit count
    always @(posedge u_rtcsb_if.ce) begin
        nbits = 0;
    end
    always @(posedge u_rtcsb_if.sclk) begin
        if (nbits < 8) begin
            hdr = {hdr[6:0], u_rtcsb_if.mosi};
        end
        nbits = nbits + 1;
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic tmo(input int k);
        if (k >= LIM) begin
            err_total++;
            $display("BAD %0t wait ran out", $time);
            end_sim();
        end
    endtask : tmo
    task automatic cmd_req(input logic [3:0] m, input logic [3:0] a, input int len);
        int k;
        cm = m;
        ca = a;
        cl = 5'(len);
        cv = 1'b1;
        for (k = 0; k < LIM && cr !== 1'b1; k++) @(negedge clk);
        tmo(k);
        @(negedge clk);
        cv = 1'b0;
    endtask : cmd_req
    // bank 2 contents left by the bank loop below
    function automatic logic [7:0] bank2_exp(input logic [3:0] a);
        case (a)
            4'he: bank2_exp = 8'h02;
            4'hf: bank2_exp = 8'h12;
            4'h0: bank2_exp = 8'h22;
            4'h1: bank2_exp = 8'h32;
            default: bank2_exp = 8'h00;
        endcase
    endfunction : bank2_exp
    task automatic xfer(input logic [3:0] m, input logic [3:0] a, input int len);
        int k;
        cmd_req(m, a, len);
        for (int i = 0; i < len; i++) begin
            if (m[3]) begin
                for (k = 0; k < LIM && rv !== 1'b1; k++) @(negedge clk);
                tmo(k);
                rbuf[i] = rd;
            end else begin
                wd = wbuf[i];
                wv = 1'b1;
                for (k = 0; k < LIM && wr !== 1'b1; k++) @(negedge clk);
                tmo(k);
            end
            @(negedge clk);
        end
        wv = 1'b0;
        for (k = 0; k < LIM && cr !== 1'b1; k++) @(negedge clk);
        tmo(k);
        chk(hdr, {m, a});
        chk(8'(nbits), 8'(8 + 8 * len));
    endtask : xfer
    // time must hold still for most of a tick period after the trigger
    task automatic tick_watch(input logic [7:0] v, input bit hw);
        int k;
        for (k = 0; k < LIM && (sec !== v || (hw && halted !== 1'b0)); k++) @(negedge clk);
        tmo(k);
        repeat (TICK - 5) begin
            @(negedge clk);
            chk(sec, v);
        end
        for (k = 0; k < 10 && sec === v; k++) @(negedge clk);
        chk(sec, v + 8'h01);
    endtask : tick_watch
    task automatic sr_watch();
        int k;
        for (k = 0; k < LIM && sres !== 1'b1; k++) @(negedge clk);
        tmo(k);
        repeat (2) @(negedge clk);
        chk(sec, 8'h00);
        chk({7'h0, halted}, 8'h00);
    endtask : sr_watch
    task automatic bb(input logic [7:0] tx, input int nb, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - nb; i--) begin
            u_rtcsb_if_2.mosi = tx[i];
            repeat (HALF) @(negedge clk);
            rx[i] = u_rtcsb_if_2.miso;
            u_rtcsb_if_2.sclk = 1'b1;
            repeat (HALF) @(negedge clk);
            u_rtcsb_if_2.sclk = 1'b0;
        end
    endtask : bb
    task automatic bb_frame(input logic [7:0] h, input logic [7:0] d, input int nb, output logic [7:0] rx);
        u_rtcsb_if_2.ce = 1'b1;
        repeat (HALF) @(negedge clk);
        bb(h, 8, rx);
        bb(d, nb, rx);
        repeat (HALF) @(negedge clk);
        u_rtcsb_if_2.ce = 1'b0;
        repeat (2 * HALF) @(negedge clk);
    endtask : bb_frame
    initial begin
        {rst_n, cv, wv, cm, ca, cl, wd} = '0;
        rr = 1'b1;
        {u_rtcsb_if_2.ce, u_rtcsb_if_2.sclk, u_rtcsb_if_2.mosi} = 3'h0;
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        wbuf[0] = 8'h40;
        xfer(`RTCSB_MODE_WR_BANK1, `RTCSB_ADDR_CTRL, 1);
        chk({halted, vdet}, 8'h02);
        wbuf = '{8'h05, 8'h3b, 8'h17, 8'h00};
        xfer(`RTCSB_MODE_WR_BANK1, `RTCSB_ADDR_SEC, 3);
        repeat (3 * TICK) @(negedge clk);
        chk(sec, 8'h05);
        chk(min, 8'h3b);
        chk(hour, 8'h17);
        xfer(`RTCSB_MODE_RD_BANK1, `RTCSB_ADDR_CTRL, 1);
        chk(rbuf[0], 8'h40);
        wbuf[0] = 8'h00;
        fork
            xfer(`RTCSB_MODE_WR_BANK1, `RTCSB_ADDR_CTRL, 1);
            tick_watch(8'h05, 1'b1);
        join
        chk({7'h0, vdet}, 8'h01);
        wbuf[0] = 8'h30;
        fork
            xfer(`RTCSB_MODE_WR_BANK1, `RTCSB_ADDR_SEC, 1);
            tick_watch(8'h30, 1'b0);
        join
        for (int b = 2; b < 4; b++) begin
            for (int i = 0; i < 4; i++) wbuf[i] = 8'(16 * i + b);
            xfer({1'b0, 3'(b)}, 4'he, 4);
            xfer({1'b1, 3'(b)}, 4'hf, 3);
            for (int i = 0; i < 3; i++) chk(rbuf[i], 8'(16 * (i + 1) + b));
        end
        xfer(`RTCSB_MODE_RD_BANK2, 4'h0, 1);
        chk(rbuf[0], 8'h22);
        for (int j = 0; j < 2; j++) begin
            wbuf[0] = 8'h40;
            xfer(`RTCSB_MODE_WR_BANK1, `RTCSB_ADDR_CTRL, 1);
            wbuf[0] = 8'h5a;
            fork
                xfer(j == 0 ? `RTCSB_MODE_WR_BANK6 : {1'b0, `RTCSB_CODE_BANK5}, 4'h0, 1);
                sr_watch();
            join
        end
        xfer(`RTCSB_MODE_RD_BANK6, 4'h0, 1);
        chk(rbuf[0], 8'h00);
        bb_frame({`RTCSB_MODE_WR_BANK2, 4'h0}, 8'h5a, 8, r);
        bb_frame({`RTCSB_MODE_WR_BANK2, 4'h0}, 8'hff, 4, r);
        bb_frame({`RTCSB_MODE_RD_BANK2, 4'h0}, 8'h00, 8, r);
        chk(r, 8'h5a);
        // 33 bytes fill the read buffer and its output stage, so the 34th parks the link clock
        rr = 1'b0;
        cmd_req(`RTCSB_MODE_RD_BANK2, 4'h0, 31);
        @(negedge clk);
        cmd_req(`RTCSB_MODE_RD_BANK2, 4'h0, 3);
        repeat (400) @(negedge clk);
        chk(8'(nbits), 8'h18);
        chk({6'h00, u_rtcsb_if.ce, u_rtcsb_if.sclk}, 8'h02);
        rr = 1'b1;
        for (n = 0; n < 34; n++) begin
            for (k = 0; k < LIM && rv !== 1'b1; k++) @(negedge clk);
            tmo(k);
            chk(rd, bank2_exp(4'(n < 31 ? n : n - 31)));
            @(negedge clk);
        end
        for (k = 0; k < LIM && cr !== 1'b1; k++) @(negedge clk);
        tmo(k);
        chk(8'(nbits), 8'h20);
        end_sim();
    end
endmodule : rtc_serial_bank_access_tb
